// ### bbx_pkg.sv
// bbx_pkg: shared types and constants of the bit-operation and branch execution unit
// assumes: one core clock, on-chip data memory of 4-bit words, 11-bit program counter
package bbx_pkg;

   localparam int PC_W  = 11;
   localparam int DM_AW = 8;
   localparam int NIB_W = 4;

   // data memory areas reached by the bit-manipulation forms
   localparam logic [3:0] FMEM_PAGE_LO = 4'hB;   // fixed area, low half
   localparam logic [3:0] FMEM_PAGE_HI = 4'hF;   // fixed area, high half
   localparam logic [5:0] PMEM_PAGE    = 6'h3F;  // port area, word picked by L[3:2]
   localparam int         FMEM_SEL_BIT = 4;      // mem field bit choosing the fixed half

   // branch boundary constants
   localparam logic [7:0]      PAGE_TAIL   = 8'hFE;    // opcode at FE/FF lands in next page
   localparam logic [PC_W-1:0] BLOCK_TAIL  = 11'h7FE;  // block jump here leaves the block
   localparam logic [4:0]      REL_BACK    = 5'h0F;    // codes below this go back 15..1
   localparam logic [4:0]      REL_MAX     = 5'h1D;    // highest legal relative code
   localparam logic [PC_W-1:0] REL_FWD_ADJ = 11'h00D;  // code 15 means +2

   typedef enum logic [4:0] {
      other_op,
      bit_force_high_op,
      bit_force_low_op,
      skip_if_bit_high_op,
      skip_if_bit_low_op,
      skip_high_then_zero_op,
      carry_and_bit_op,
      carry_or_bit_op,
      carry_xor_bit_op,
      jump_op,
      long_jump_op,
      rel_jump_op,
      block_jump_op,
      page_jump_via_de_pair,
      page_jump_via_xa_pair,
      full_jump_via_four_regs_d,
      full_jump_via_four_regs_a
   } bbx_op_t;

   typedef enum logic [1:0] {
      am_direct,
      am_fixed,
      am_port,
      am_hplus
   } bbx_amode_t;

   // one decoded instruction as handed over by the fetch stage
   typedef struct packed {
      bbx_op_t         op;
      bbx_amode_t      amode;
      logic [7:0]      mem;      // 8-bit data address, or bit 4 plus low nibble for fixed, low nibble for H+mem
      logic [1:0]      bitn;     // bit number 0-3
      logic [PC_W-1:0] target;   // absolute or block target
      logic [4:0]      rel;      // relative code 0..29
      logic [PC_W-1:0] op_addr;  // address of the first opcode byte
      logic [1:0]      len;      // length in bytes, 1..3
   } bbx_instr_t;

   // general registers read by addressing and indirect branches
   typedef struct packed {
      logic [3:0] x;
      logic [3:0] a;
      logic [3:0] b;
      logic [3:0] c;
      logic [3:0] d;
      logic [3:0] e;
      logic [3:0] h;
      logic [3:0] l;
   } bbx_regs_t;

endpackage

// ### bbx_bit_addr.sv
// bbx_bit_addr: turns an addressing form into a data word address and bit number
// assumes: purely combinational, registers H and L sampled by the caller
`timescale 1ns/1ps
module bbx_bit_addr
   import bbx_pkg::*;
(
   input  wire bbx_amode_t   amode,
   input  wire logic [7:0]   mem,
   input  wire logic [1:0]   bitn,
   input  wire logic [3:0]   h,
   input  wire logic [3:0]   l,
   output logic [DM_AW-1:0]  word_addr,
   output logic [1:0]        bit_sel
);

   // address build for direct, fixed-area, port-area and H+mem forms
   always_comb begin
      word_addr = mem;
      bit_sel   = bitn;
      unique case (amode)
         am_direct: begin
            word_addr = mem;
         end
         am_fixed: begin
            word_addr = {mem[FMEM_SEL_BIT] ? FMEM_PAGE_HI : FMEM_PAGE_LO, mem[3:0]};
         end
         am_port: begin
            word_addr = {PMEM_PAGE, l[3:2]};  // bit number also comes from L
            bit_sel   = l[1:0];
         end
         am_hplus: begin
            word_addr = {h, mem[3:0]};
         end
      endcase
   end

endmodule

// ### bbx_exec.sv
// bbx_exec: executes single-bit data memory operations and program branches
// assumes: fetch stage offers one decoded instruction at a time with valid/ready,
// data memory returns read data in the cycle after dm_rd_en and writes on dm_wr_en
//
// How it works
// RULE_01 - direct bit force-high sets chosen bit of word at 8-bit address
// RULE_02 - direct bit force-low clears chosen bit of word at 8-bit address
// RULE_03 - force ops also take fixed, port and H+mem forms, touching one bit
// RULE_04 - direct skip-if-high skips next instruction when bit reads 1
// RULE_05 - direct skip-if-low skips next instruction when bit reads 0
// RULE_06 - both skip tests also work with the three bit-manipulation forms
// RULE_07 - skip-high-then-zero skips when bit is 1 and writes it to 0
// RULE_08 - carry-and replaces carry with carry AND selected bit
// RULE_09 - carry-or replaces carry with carry OR selected bit
// RULE_10 - carry-xor replaces carry with carry XOR selected bit
// RULE_11 - absolute jumps load all 11 counter bits with the target
// RULE_12 - relative jump reaches -15..-1 and +2..+16, ignoring page and block
// RULE_13 - block jump loads low 11 bits; at 07FE it leaves for next block
// RULE_14 - DE page jump loads counter bits 7-4 from D, 3-0 from E
// RULE_15 - page jump opcode at FE or FF lands in the next page
// RULE_16 - XA page jump loads bits 7-4 from X, 3-0 from A, same page rule
// RULE_17 - B,C,D,E jump builds counter from C, D, E; B must be zero
// RULE_18 - B,C,X,A jump builds counter from C, X, A; B must be zero
// RULE_19 - skipped instruction is consumed with no effect, then execution resumes
`timescale 1ns/1ps
module bbx_exec
   import bbx_pkg::*;
#(
   parameter int CNT_W = PC_W
)
(
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   input  wire logic             instr_valid,
   input  wire bbx_instr_t       instr,
   input  wire bbx_regs_t        regs,
   output logic                  instr_ready,
   output logic [DM_AW-1:0]      dm_addr,
   output logic                  dm_rd_en,
   input  wire logic [NIB_W-1:0] dm_rd_data,
   output logic                  dm_wr_en,
   output logic [NIB_W-1:0]      dm_wr_data,
   output logic [PC_W-1:0]       pc,
   output logic                  carry_flag,
   output logic                  skip_pending,
   output logic                  retire,
   output logic                  illegal_op,
   output logic                  block_exit
);

   // the register-indirect jumps pack 3+4+4 bits, so the counter must be exactly this wide
   if (CNT_W != PC_W) begin : g_bad_width
      $error("bbx_exec: CNT_W must equal the 11-bit program counter width");
   end

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_READ,
      ST_EXEC
   } bbx_state_t;

   bbx_state_t        state_ff,   nxt_state;
   bbx_instr_t        op_ff,      nxt_op;
   logic [PC_W-1:0]   pc_ff,      nxt_pc;
   logic              carry_ff,   nxt_carry;
   logic              skip_ff,    nxt_skip;
   logic              retire_ff,  nxt_retire;
   logic              illegal_ff, nxt_illegal;
   logic              bexit_ff,   nxt_bexit;
   logic [DM_AW-1:0]  addr_ff,    nxt_addr;
   logic [1:0]        bsel_ff,    nxt_bsel;
   logic              rd_ff,      nxt_rd;
   logic              wr_ff,      nxt_wr;
   logic [NIB_W-1:0]  wdata_ff,   nxt_wdata;

   logic [DM_AW-1:0]  res_addr;
   logic [1:0]        res_bit;
   logic              is_bit_op;
   logic              amode_ok;
   logic              sel_bit;
   logic [PC_W-1:0]   pc_seq;
   logic [PC_W-1:0]   rel_tgt;
   logic [2:0]        page_hi;
   logic              take;

   bbx_bit_addr u_bit_addr (
      .amode     (instr.amode),
      .mem       (instr.mem),
      .bitn      (instr.bitn),
      .h         (regs.h),
      .l         (regs.l),
      .word_addr (res_addr),
      .bit_sel   (res_bit)
   );

   // decode helpers for the instruction on offer
   always_comb begin
      is_bit_op = instr.op inside {bit_force_high_op, bit_force_low_op, skip_if_bit_high_op,
                                   skip_if_bit_low_op, skip_high_then_zero_op, carry_and_bit_op,
                                   carry_or_bit_op, carry_xor_bit_op};
      // direct form exists only for force and plain skip ops
      amode_ok  = (instr.amode != am_direct) ||
                  (instr.op inside {bit_force_high_op, bit_force_low_op,
                                    skip_if_bit_high_op, skip_if_bit_low_op});
      pc_seq    = instr.op_addr + PC_W'(instr.len);
      // relative code 0..14 is -15..-1, code 15..29 is +2..+16
      if (instr.rel < REL_BACK) begin
         rel_tgt = instr.op_addr - PC_W'(REL_BACK) + PC_W'(instr.rel); // RULE_12
      end else begin
         rel_tgt = instr.op_addr + PC_W'(instr.rel) - REL_FWD_ADJ;     // RULE_12
      end
      // page jumps starting on the last two bytes of a page go one page up
      page_hi   = instr.op_addr[PC_W-1:8] + ((instr.op_addr[7:0] >= PAGE_TAIL) ? 3'h1 : 3'h0); // RULE_15
      sel_bit   = dm_rd_data[bsel_ff];
      take      = instr_valid && instr_ready;
   end

   // next-state for the fetch handshake, branches, skip and bit operations
   always_comb begin
      nxt_state   = state_ff;
      nxt_op      = op_ff;
      nxt_pc      = pc_ff;
      nxt_carry   = carry_ff;
      nxt_skip    = skip_ff;
      nxt_retire  = 1'b0;
      nxt_illegal = 1'b0;
      nxt_bexit   = 1'b0;
      nxt_addr    = addr_ff;
      nxt_bsel    = bsel_ff;
      nxt_rd      = 1'b0;
      nxt_wr      = 1'b0;
      nxt_wdata   = wdata_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (take) begin
               nxt_pc     = pc_seq;
               nxt_retire = 1'b1;
               if (skip_ff) begin
                  nxt_skip = 1'b0;                           // RULE_19
               end else if (is_bit_op) begin
                  if (amode_ok) begin
                     nxt_state  = ST_READ;
                     nxt_op     = instr;
                     nxt_addr   = res_addr;                  // RULE_03
                     nxt_bsel   = res_bit;
                     nxt_rd     = 1'b1;
                     nxt_retire = 1'b0;
                  end else begin
                     nxt_illegal = 1'b1;
                  end
               end else begin
                  unique case (instr.op)
                     jump_op, long_jump_op: begin
                        nxt_pc = instr.target;                // RULE_11
                     end
                     rel_jump_op: begin
                        if (instr.rel <= REL_MAX) begin
                           nxt_pc = rel_tgt;                  // RULE_12
                        end else begin
                           nxt_illegal = 1'b1;
                        end
                     end
                     block_jump_op: begin
                        nxt_pc    = instr.target;             // RULE_13
                        nxt_bexit = (instr.op_addr == BLOCK_TAIL); // RULE_13
                     end
                     page_jump_via_de_pair: begin
                        nxt_pc = {page_hi, regs.d, regs.e};   // RULE_14
                     end
                     page_jump_via_xa_pair: begin
                        nxt_pc = {page_hi, regs.x, regs.a};   // RULE_16
                     end
                     full_jump_via_four_regs_d: begin
                        nxt_pc      = {regs.c[2:0], regs.d, regs.e}; // RULE_17
                        nxt_illegal = (regs.b != 4'h0) || regs.c[3]; // RULE_17
                     end
                     full_jump_via_four_regs_a: begin
                        nxt_pc      = {regs.c[2:0], regs.x, regs.a}; // RULE_18
                        nxt_illegal = (regs.b != 4'h0) || regs.c[3]; // RULE_18
                     end
                     default: begin
                        nxt_pc = pc_seq;                     // other groups only advance
                     end
                  endcase
               end
            end
         end
         ST_READ: begin
            nxt_state = ST_EXEC;                             // memory answers next cycle
         end
         ST_EXEC: begin
            nxt_state  = ST_IDLE;
            nxt_retire = 1'b1;
            nxt_wdata  = dm_rd_data;
            unique case (op_ff.op)
               bit_force_high_op: begin
                  nxt_wr              = 1'b1;
                  nxt_wdata[bsel_ff]  = 1'b1;                // RULE_01
               end
               bit_force_low_op: begin
                  nxt_wr              = 1'b1;
                  nxt_wdata[bsel_ff]  = 1'b0;                // RULE_02
               end
               skip_if_bit_high_op: begin
                  nxt_skip = sel_bit;                        // RULE_04 RULE_06
               end
               skip_if_bit_low_op: begin
                  nxt_skip = !sel_bit;                       // RULE_05 RULE_06
               end
               skip_high_then_zero_op: begin
                  nxt_skip            = sel_bit;             // RULE_07
                  nxt_wr              = 1'b1;
                  nxt_wdata[bsel_ff]  = 1'b0;                // RULE_07
               end
               carry_and_bit_op: begin
                  nxt_carry = carry_ff & sel_bit;            // RULE_08
               end
               carry_or_bit_op: begin
                  nxt_carry = carry_ff | sel_bit;            // RULE_09
               end
               carry_xor_bit_op: begin
                  nxt_carry = carry_ff ^ sel_bit;            // RULE_10
               end
               default: begin
                  nxt_wr = 1'b0;
               end
            endcase
         end
      endcase
   end

   // state registers only
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff   <= ST_IDLE;
         op_ff      <= '0;
         pc_ff      <= '0;
         carry_ff   <= 1'b0;
         skip_ff    <= 1'b0;
         retire_ff  <= 1'b0;
         illegal_ff <= 1'b0;
         bexit_ff   <= 1'b0;
         addr_ff    <= '0;
         bsel_ff    <= '0;
         rd_ff      <= 1'b0;
         wr_ff      <= 1'b0;
         wdata_ff   <= '0;
      end else begin
         state_ff   <= nxt_state;
         op_ff      <= nxt_op;
         pc_ff      <= nxt_pc;
         carry_ff   <= nxt_carry;
         skip_ff    <= nxt_skip;
         retire_ff  <= nxt_retire;
         illegal_ff <= nxt_illegal;
         bexit_ff   <= nxt_bexit;
         addr_ff    <= nxt_addr;
         bsel_ff    <= nxt_bsel;
         rd_ff      <= nxt_rd;
         wr_ff      <= nxt_wr;
         wdata_ff   <= nxt_wdata;
      end
   end

   // ready is held low during the write-back cycle so a following read never sees stale data
   assign instr_ready  = (state_ff == ST_IDLE) && !wr_ff;
   assign dm_addr      = addr_ff;
   assign dm_rd_en     = rd_ff;
   assign dm_wr_en     = wr_ff;
   assign dm_wr_data   = wdata_ff;
   assign pc           = pc_ff;
   assign carry_flag   = carry_ff;
   assign skip_pending = skip_ff;
   assign retire       = retire_ff;
   assign illegal_op   = illegal_ff;
   assign block_exit   = bexit_ff;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // only the selected bit may change in a write-back
   logic [NIB_W-1:0] other_mask;
   assign other_mask = ~(NIB_W'(1) << bsel_ff);

   AST_FORCE_HIGH: assert property (state_ff == ST_EXEC && op_ff.op == bit_force_high_op |=> // RULE_01
      dm_wr_en && dm_wr_data[bsel_ff] && dm_addr == $past(addr_ff))
      else $error("force-high did not write a one");
   AST_FORCE_LOW: assert property (state_ff == ST_EXEC && op_ff.op == bit_force_low_op |=> // RULE_02
      dm_wr_en && !dm_wr_data[bsel_ff])
      else $error("force-low did not write a zero");
   AST_ONE_BIT: assert property (state_ff == ST_EXEC |=> // RULE_03
      ((dm_wr_data ^ $past(dm_rd_data)) & other_mask) == '0)
      else $error("write-back touched a bit outside the selected one");
   AST_SKIP_HIGH: assert property (state_ff == ST_EXEC && op_ff.op == skip_if_bit_high_op |=> // RULE_04
      skip_pending == $past(sel_bit))
      else $error("skip-if-high decision wrong");
   AST_SKIP_LOW: assert property (state_ff == ST_EXEC && op_ff.op == skip_if_bit_low_op |=> // RULE_05
      skip_pending == !$past(sel_bit))
      else $error("skip-if-low decision wrong");
   AST_SKIP_ZERO: assert property (state_ff == ST_EXEC && op_ff.op == skip_high_then_zero_op && sel_bit |=> // RULE_07
      skip_pending && dm_wr_en && !dm_wr_data[bsel_ff])
      else $error("skip-high-then-zero failed to skip or clear");
   AST_CARRY_AND: assert property (state_ff == ST_EXEC && op_ff.op == carry_and_bit_op |=> // RULE_08
      carry_flag == ($past(carry_flag) & $past(sel_bit)))
      else $error("carry-and result wrong");
   AST_CARRY_OR: assert property (state_ff == ST_EXEC && op_ff.op == carry_or_bit_op |=> // RULE_09
      carry_flag == ($past(carry_flag) | $past(sel_bit)))
      else $error("carry-or result wrong");
   AST_CARRY_XOR: assert property (state_ff == ST_EXEC && op_ff.op == carry_xor_bit_op |=> // RULE_10
      carry_flag == ($past(carry_flag) ^ $past(sel_bit)))
      else $error("carry-xor result wrong");
   AST_ABS_JUMP: assert property (take && !skip_ff && instr.op == jump_op |=> pc == $past(instr.target)) // RULE_11
      else $error("absolute jump target not loaded");
   AST_PAGE_NEXT: assert property (take && !skip_ff && instr.op == page_jump_via_de_pair && // RULE_15
      instr.op_addr[7:0] >= PAGE_TAIL |=> pc[PC_W-1:8] == $past(instr.op_addr[PC_W-1:8]) + 3'h1)
      else $error("page jump at page end stayed in page");
   AST_FULL_JUMP: assert property (take && !skip_ff && instr.op == full_jump_via_four_regs_a |=> // RULE_18
      pc == {$past(regs.c[2:0]), $past(regs.x), $past(regs.a)})
      else $error("four-register jump target wrong");
   AST_SKIP_CONSUME: assert property (take && skip_ff |=> !skip_pending && !dm_rd_en && // RULE_19
      pc == $past(pc_seq) ##1 !dm_wr_en)
      else $error("skipped instruction had an effect");

   COV_SKIP: cover property (state_ff == ST_EXEC && op_ff.op == skip_high_then_zero_op && sel_bit ##2 take);
   COV_PAGE: cover property (take && instr.op == page_jump_via_xa_pair && instr.op_addr[7:0] == 8'hFF);
   COV_REL:  cover property (take && instr.op == rel_jump_op && instr.rel == 5'h00);
   COV_BLOCK: cover property (block_exit);

endmodule

// ### bbx_dm_model.sv
// bbx_dm_model: behavioural data memory seen from the execution unit
// assumes: read data is due one cycle after dm_rd_en; writes land at the clock edge
`timescale 1ns/1ps
module bbx_dm_model
   import bbx_pkg::*;
(
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   input  wire logic [DM_AW-1:0] dm_addr,
   input  wire logic             dm_rd_en,
   output logic [NIB_W-1:0]      dm_rd_data,
   input  wire logic             dm_wr_en,
   input  wire logic [NIB_W-1:0] dm_wr_data
);
   logic [NIB_W-1:0] mem [256];
   logic [NIB_W-1:0] q_ff;

   // read data holds for one cycle only, then toggles so a late sample shows garbage
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         q_ff <= 4'h0;
      end else if (dm_rd_en) begin
         q_ff <= mem[dm_addr];
      end else begin
         q_ff <= ~q_ff;
      end
   end

   // plain always so the bench may preload words between instructions
   always @(posedge ref_clk) begin
      if (dm_wr_en) begin
         mem[dm_addr] <= dm_wr_data;
      end
   end

   assign dm_rd_data = q_ff;
endmodule

// ### tb_top.sv
// tb_top: self-checking bench for the bit-operation and branch execution unit
// assumes: bbx_exec fed one decoded instruction at a time, data memory modelled aside
`timescale 1ns/1ps
module tb_top;
   import bbx_pkg::*;
   logic             ref_clk, rst_n, instr_valid, instr_ready;
   bbx_instr_t       instr;
   bbx_regs_t        regs, rz;
   logic [DM_AW-1:0] dm_addr, wr_addr;
   logic             dm_rd_en, dm_wr_en, carry_flag, skip_pending, retire, illegal_op, block_exit;
   logic [NIB_W-1:0] dm_rd_data, dm_wr_data, wr_data;
   logic [PC_W-1:0]  pc;
   logic             saw_wr, bexit, ill;
   int               error_cnt, cmp_count;

   bbx_exec #(.CNT_W(PC_W)) i_bbx_exec (.ref_clk(ref_clk), .rst_n(rst_n), .instr_valid(instr_valid),
      .instr(instr), .regs(regs), .instr_ready(instr_ready), .dm_addr(dm_addr), .dm_rd_en(dm_rd_en),
      .dm_rd_data(dm_rd_data), .dm_wr_en(dm_wr_en), .dm_wr_data(dm_wr_data), .pc(pc),
      .carry_flag(carry_flag), .skip_pending(skip_pending), .retire(retire), .illegal_op(illegal_op),
      .block_exit(block_exit));
   bbx_dm_model i_bbx_dm_model (.ref_clk(ref_clk), .rst_n(rst_n), .dm_addr(dm_addr), .dm_rd_en(dm_rd_en),
      .dm_rd_data(dm_rd_data), .dm_wr_en(dm_wr_en), .dm_wr_data(dm_wr_data));

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   task automatic close_out;
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (exp !== got) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask

   function automatic bbx_instr_t mk(bbx_op_t op, bbx_amode_t am, logic [7:0] m, logic [1:0] b,
                                     logic [10:0] t, logic [4:0] r, logic [10:0] oa);
      return '{op: op, amode: am, mem: m, bitn: b, target: t, rel: r, op_addr: oa, len: 2'd2};
   endfunction

   // offer one instruction, hold it until taken, then collect what it did up to retire
   task automatic run(input bbx_instr_t ins, input bbx_regs_t rg);
      int n;
      @(posedge ref_clk);
      instr <= ins;
      regs <= rg;
      instr_valid <= 1'b1;
      n = 0;
      @(negedge ref_clk);
      while (instr_ready !== 1'b1 && n < 8) begin
         n++;
         @(negedge ref_clk);
      end
      // a fetch that is never accepted is a mismatch, not a silent pass
      if (instr_ready !== 1'b1) begin
         error_cnt++;
         $display("unexpected instr_ready expected 1 seen %b", instr_ready);
         close_out();
      end
      @(posedge ref_clk);
      instr_valid <= 1'b0;
      saw_wr = 1'b0;
      wr_addr = 'x;
      wr_data = 'x;
      n = 0;
      do begin
         @(negedge ref_clk);
         n++;
         if (dm_wr_en === 1'b1) begin
            saw_wr = 1'b1;
            wr_addr = dm_addr;
            wr_data = dm_wr_data;
         end
      end while (retire !== 1'b1 && n < 8);
      bexit = block_exit;
      ill = illegal_op;
      if (retire !== 1'b1) begin
         error_cnt++;
         $display("unexpected retire expected 1 seen %b", retire);
         close_out();
      end
   endtask

   task automatic t_force;
      for (int b = 0; b < 4; b++) begin
         i_bbx_dm_model.mem[8'hA5] = 4'h0;
         run(mk(bit_force_high_op, am_direct, 8'hA5, b[1:0], '0, '0, 11'h100), rz);
         chk("set_data", 4'h1 << b, wr_data);
         chk("set_addr", 8'hA5, wr_addr);
         i_bbx_dm_model.mem[8'h5A] = 4'hF;
         run(mk(bit_force_low_op, am_direct, 8'h5A, b[1:0], '0, '0, 11'h104), rz);
         chk("clr_data", 4'hF & ~(4'h1 << b), wr_data);
         chk("clr_pc", 11'h106, pc);
      end
   endtask

   // each bit-manipulation form must reach its own word and touch one bit
   task automatic form_case(bbx_amode_t am, logic [7:0] m, logic [1:0] b, bbx_regs_t rg,
                            logic [7:0] wa, logic [1:0] eb);
      i_bbx_dm_model.mem[wa] = 4'h0;
      run(mk(bit_force_high_op, am, m, b, '0, '0, 11'h120), rg);
      chk("form_addr", wa, wr_addr);
      chk("form_data", 4'h1 << eb, wr_data);
   endtask

   // the instruction after a taken skip is consumed with no write
   task automatic skip_case(bbx_op_t op, bbx_amode_t am, logic [7:0] m, logic [7:0] wa,
                            logic [3:0] v, logic exp);
      i_bbx_dm_model.mem[wa] = v;
      run(mk(op, am, m, 2'd2, '0, '0, 11'h200), rz);
      chk("skip", exp, skip_pending);
      run(mk(bit_force_high_op, am_direct, 8'h40, 2'd0, '0, '0, 11'h202), rz);
      chk("consume_wr", !exp, saw_wr);
      chk("consume_pc", 11'h204, pc);
      chk("skip_clr", 1'b0, skip_pending);
   endtask

   task automatic carry_case(bbx_op_t op, logic [1:0] b, logic exp);
      run(mk(op, am_fixed, 8'h15, b, '0, '0, 11'h300), rz);
      chk("carry", exp, carry_flag);
   endtask

   task automatic jump_case(bbx_op_t op, logic [10:0] t, logic [4:0] r, logic [10:0] oa,
                            bbx_regs_t rg, logic [10:0] exp);
      run(mk(op, am_direct, 8'h00, 2'd0, t, r, oa), rg);
      chk("jump_pc", exp, pc);
   endtask

   initial begin
      error_cnt = 0;
      cmp_count = 0;
      rst_n = 1'b0;
      instr_valid = 1'b0;
      instr = '0;
      regs = '0;
      rz = '0;
      repeat (8) @(posedge ref_clk);
      chk("reset_pc", 11'h000, pc);
      chk("reset_ready", 1'b1, instr_ready);
      rst_n <= 1'b1;
      t_force();
      form_case(am_fixed, 8'h13, 2'd1, rz, 8'hF3, 2'd1);
      form_case(am_fixed, 8'h03, 2'd2, rz, 8'hB3, 2'd2);
      form_case(am_port, 8'h00, 2'd0, '{l: 4'hB, default: 4'h0}, 8'hFE, 2'd3);
      form_case(am_hplus, 8'h09, 2'd0, '{h: 4'h7, default: 4'h0}, 8'h79, 2'd0);
      skip_case(skip_if_bit_high_op, am_direct, 8'h60, 8'h60, 4'h4, 1'b1);
      skip_case(skip_if_bit_high_op, am_direct, 8'h60, 8'h60, 4'hB, 1'b0);
      skip_case(skip_if_bit_low_op, am_direct, 8'h61, 8'h61, 4'h4, 1'b0);
      skip_case(skip_if_bit_low_op, am_direct, 8'h61, 8'h61, 4'h0, 1'b1);
      skip_case(skip_if_bit_high_op, am_fixed, 8'h13, 8'hF3, 4'h4, 1'b1);
      skip_case(skip_if_bit_low_op, am_fixed, 8'h03, 8'hB3, 4'h0, 1'b1);
      skip_case(skip_high_then_zero_op, am_fixed, 8'h12, 8'hF2, 4'hF, 1'b1);
      chk("tclr_word", 4'hB, i_bbx_dm_model.mem[8'hF2]);
      i_bbx_dm_model.mem[8'hF5] = 4'h5;
      carry_case(carry_or_bit_op, 2'd0, 1'b1);
      carry_case(carry_and_bit_op, 2'd1, 1'b0);
      carry_case(carry_xor_bit_op, 2'd0, 1'b1);
      carry_case(carry_and_bit_op, 2'd0, 1'b1);
      carry_case(carry_xor_bit_op, 2'd0, 1'b0);
      jump_case(jump_op, 11'h5A3, '0, 11'h010, rz, 11'h5A3);
      jump_case(long_jump_op, 11'h7FF, '0, 11'h5A3, rz, 11'h7FF);
      jump_case(rel_jump_op, '0, 5'd0, 11'h400, rz, 11'h3F1);
      jump_case(rel_jump_op, '0, 5'd14, 11'h400, rz, 11'h3FF);
      jump_case(rel_jump_op, '0, 5'd15, 11'h4FF, rz, 11'h501);
      jump_case(rel_jump_op, '0, 5'd29, 11'h400, rz, 11'h410);
      jump_case(block_jump_op, 11'h456, '0, 11'h123, rz, 11'h456);
      chk("block_exit", 1'b0, bexit);
      jump_case(block_jump_op, 11'h456, '0, 11'h7FE, rz, 11'h456);
      chk("block_exit", 1'b1, bexit);
      jump_case(page_jump_via_de_pair, '0, '0, 11'h2A0, '{d: 4'h7, e: 4'hC, default: 4'h0}, 11'h27C);
      jump_case(page_jump_via_de_pair, '0, '0, 11'h2FE, '{d: 4'h7, e: 4'hC, default: 4'h0}, 11'h37C);
      jump_case(page_jump_via_xa_pair, '0, '0, 11'h2FF, '{x: 4'h1, a: 4'h2, default: 4'h0}, 11'h312);
      jump_case(page_jump_via_xa_pair, '0, '0, 11'h150, '{x: 4'h9, a: 4'h4, default: 4'h0}, 11'h194);
      jump_case(full_jump_via_four_regs_d, '0, '0, 11'h010,
                '{c: 4'h5, d: 4'hA, e: 4'h3, default: 4'h0}, 11'h5A3);
      chk("four_reg_ok", 1'b0, ill);
      jump_case(full_jump_via_four_regs_a, '0, '0, 11'h010,
                '{c: 4'h2, x: 4'hE, a: 4'h1, default: 4'h0}, 11'h2E1);
      jump_case(full_jump_via_four_regs_a, '0, '0, 11'h010,
                '{b: 4'h1, c: 4'h2, x: 4'hE, a: 4'h1, default: 4'h0}, 11'h2E1);
      chk("four_reg_bad", 1'b1, ill);
      jump_case(rel_jump_op, '0, 5'd30, 11'h400, rz, 11'h402);
      chk("rel_bad", 1'b1, ill);
      // carry ops have no direct form: refused, carry left alone, pc just advances
      jump_case(carry_or_bit_op, '0, '0, 11'h500, rz, 11'h502);
      chk("direct_bad", 1'b1, ill);
      chk("direct_cy", 1'b0, carry_flag);
      close_out();
   end
endmodule
